// ---- core/i2csa_top.sv ----
// How it works
// - receive event at eighth scl falling edge
// - first byte taken from holding register first
// - compare address; pick buffer by direction bit
// - scl held at eighth fall for every address; on match ack ninth slot
// - on match disable receive, enable transmit, stop
// - on match zero byte count, clear statuses
// - slave receive pre-arms ack for next byte
// - slave transmit loads first outgoing byte
// - on mismatch nack and stay out
// - release scl hold after decision and setup
// - transmit event at ninth fall; drop ack
// - stop restores settings, sets done flag after a match
`default_nettype none
module i2csa_top
	import i2csa_pkg::*;
(
	input  wire logic       sys_clk,                   // system clock, 250 MHz
	input  wire logic       reset,                     // async reset, active high
	input  wire logic       ce,                        // clock enable, freezes all state
	input  wire logic       serial_clock_line_pin_in,  // scl pin level
	output logic            serial_clock_line_pin_out, // scl drive value, always low
	output logic            serial_clock_line_pin_oe,  // scl pulled low while high
	input  wire logic       serial_data_pin_in,        // sda pin level
	output logic            serial_data_pin_out,       // sda drive value, always low
	output logic            serial_data_pin_oe,        // sda pulled low while high
	input  wire logic [6:0] own_addr,                  // own 7-bit slave address
	input  wire logic [7:0] tx_data,                   // first outgoing byte
	input  wire logic       done_clr,                  // clears done flag, pulse
	output logic [7:0]      rx_holding_register,       // captured first byte
	output logic            rx_event,                  // receive event pulse
	output logic            tx_event,                  // transmit event pulse
	output logic            rx_event_en,               // receive event enable
	output logic            tx_event_en,               // transmit event enable
	output logic            stop_event_en,             // stop detection enable
	output i2csa_buf_t      buffer_sel,                // selected buffer
	output logic            slave_tx,                  // direction of matched transfer
	output logic            ack_armed,                 // ack pre-armed for next byte
	output logic [7:0]      tx_shift,                  // transmit shift path
	output logic [7:0]      byte_count,                // transferred bytes
	output logic [1:0]      status                     // mismatch, done
);
	i2csa_line_if line ();

	i2csa_state_t state;
	logic [7:0]   shift;
	logic [3:0]   bit_cnt;
	logic         addr_hit;

	i2csa_line_sync u_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.ce      (ce),
		.scl_in  (serial_clock_line_pin_in),
		.sda_in  (serial_data_pin_in),
		.line    (line.producer)
	);

	function automatic logic addr_equal(input logic [7:0] b, input logic [6:0] a);
		return b[7:1] == a;
	endfunction

	// eighth address bit clocked in and its scl fall seen
	function automatic logic addr_last(input i2csa_state_t st, input logic fall,
		input logic [3:0] cnt);
		return st == I2CSA_ADDR && fall && cnt == I2CSA_BITS_ADDR;
	endfunction

	assign serial_clock_line_pin_out = 1'h0;
	assign serial_data_pin_out       = 1'h0;
	assign addr_hit = addr_equal(rx_holding_register, own_addr);

	// main sequence
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state <= I2CSA_IDLE;
		end else if (ce) begin
			if (line.stop_det)
				state <= I2CSA_IDLE;
			else if (line.start_det)
				state <= I2CSA_ADDR;
			else begin
				case (state)
					I2CSA_ADDR: begin
						if (addr_last(state, line.scl_fall, bit_cnt))
							state <= I2CSA_DECIDE;
					end
					I2CSA_DECIDE: begin
						state <= addr_hit ? I2CSA_ACK : I2CSA_IGNORE;
					end
					I2CSA_ACK: begin
						if (line.scl_fall)
							state <= I2CSA_XFER;
					end
					default: begin
						state <= state;
					end
				endcase
			end
		end
	end

	// bit counting and address shifting
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bit_cnt <= 4'h0;
			shift   <= 8'h00;
		end else if (ce) begin
			if (line.start_det || state == I2CSA_ACK)
				bit_cnt <= 4'h0;
			// address bits counted on rises, so the fall after start is no bit
			else if (line.scl_rise && state == I2CSA_ADDR)
				bit_cnt <= bit_cnt + 4'h1;
			else if (line.scl_fall && state == I2CSA_XFER)
				bit_cnt <= (bit_cnt == I2CSA_BITS_SLOT - 4'h1) ? 4'h0 : bit_cnt + 4'h1;
			if (line.scl_rise && state == I2CSA_ADDR)
				shift <= {shift[6:0], line.sda_level};
		end
	end

	// first byte capture and event pulses
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rx_holding_register <= 8'h00;
			rx_event            <= 1'h0;
			tx_event            <= 1'h0;
		end else if (ce) begin
			rx_event <= 1'h0;
			tx_event <= 1'h0;
			if (addr_last(state, line.scl_fall, bit_cnt)
				&& !line.start_det && !line.stop_det) begin
				rx_holding_register <= shift;
				rx_event            <= rx_event_en;
			end
			if (line.scl_fall && tx_event_en && !line.stop_det
				&& (state == I2CSA_ACK
				|| (state == I2CSA_XFER && bit_cnt == I2CSA_BITS_SLOT - 4'h1)))
				tx_event <= 1'h1;
		end
	end

	// scl stretch and sda drive
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			serial_clock_line_pin_oe <= 1'h0;
			serial_data_pin_oe       <= 1'h0;
		end else if (ce) begin
			if (line.stop_det || line.start_det) begin
				serial_clock_line_pin_oe <= 1'h0;
				serial_data_pin_oe       <= 1'h0;
			end else if (addr_last(state, line.scl_fall, bit_cnt)) begin
				serial_clock_line_pin_oe <= 1'h1;
			end else if (state == I2CSA_DECIDE) begin
				serial_clock_line_pin_oe <= 1'h0;
				serial_data_pin_oe       <= addr_hit;
			end else if (state == I2CSA_ACK && line.scl_fall) begin
				serial_data_pin_oe <= 1'h0;
			end else if (state == I2CSA_XFER && line.scl_fall) begin
				// pre-armed ack covers the ninth slot of each received byte
				serial_data_pin_oe <= !slave_tx && ack_armed
					&& bit_cnt == I2CSA_BITS_ADDR - 4'h1;
			end
		end
	end

	// channel settings chosen by the address decision
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rx_event_en   <= I2CSA_RX_EN_INIT;
			tx_event_en   <= I2CSA_TX_EN_INIT;
			stop_event_en <= I2CSA_STOP_EN_INIT;
			buffer_sel    <= I2CSA_BUF_NONE;
			slave_tx      <= 1'h0;
			ack_armed     <= 1'h0;
			tx_shift      <= 8'h00;
		end else if (ce) begin
			if (line.stop_det) begin
				rx_event_en   <= I2CSA_RX_EN_INIT;
				tx_event_en   <= I2CSA_TX_EN_INIT;
				stop_event_en <= I2CSA_STOP_EN_INIT;
				buffer_sel    <= I2CSA_BUF_NONE;
				slave_tx      <= 1'h0;
				ack_armed     <= 1'h0;
			end else if (state == I2CSA_DECIDE) begin
				if (addr_hit) begin
					rx_event_en   <= 1'h0;
					tx_event_en   <= 1'h1;
					stop_event_en <= 1'h1;
					slave_tx      <= rx_holding_register[I2CSA_RW_POS];
					if (rx_holding_register[I2CSA_RW_POS] == I2CSA_RW_SLAVE_TX) begin
						buffer_sel <= I2CSA_BUF_TX;
						tx_shift   <= tx_data;
						ack_armed  <= 1'h0;
					end else begin
						buffer_sel <= I2CSA_BUF_RX;
						ack_armed  <= 1'h1;
					end
				end else begin
					buffer_sel <= I2CSA_BUF_NONE;
				end
			end
		end
	end

	// byte counter and communication statuses; done set beats its clear
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			byte_count <= I2CSA_COUNT_INIT;
			status     <= I2CSA_STATUS_INIT;
		end else if (ce) begin
			if (state == I2CSA_DECIDE && addr_hit) begin
				byte_count <= I2CSA_COUNT_INIT;
				status     <= I2CSA_STATUS_INIT;
			end else begin
				if (state == I2CSA_XFER && line.scl_fall && !line.stop_det
					&& bit_cnt == I2CSA_BITS_SLOT - 4'h1)
					byte_count <= byte_count + 8'h01;
				if (state == I2CSA_DECIDE)
					status[I2CSA_ST_MISMATCH] <= 1'h1;
				if (line.stop_det && stop_event_en)
					status[I2CSA_ST_DONE] <= 1'h1;
				else if (done_clr)
					status[I2CSA_ST_DONE] <= 1'h0;
			end
		end
	end
endmodule // i2csa_top
`default_nettype wire

// ---- core/i2csa_pkg.sv ----
`default_nettype none
package i2csa_pkg;
	typedef enum logic [2:0] {
		I2CSA_IDLE   = 3'h0,
		I2CSA_ADDR   = 3'h1,
		I2CSA_DECIDE = 3'h3,
		I2CSA_ACK    = 3'h2,
		I2CSA_XFER   = 3'h6,
		I2CSA_IGNORE = 3'h4
	} i2csa_state_t;

	typedef enum logic [1:0] {
		I2CSA_BUF_NONE = 2'h0,
		I2CSA_BUF_RX   = 2'h1,
		I2CSA_BUF_TX   = 2'h2
	} i2csa_buf_t;

	localparam logic [3:0] I2CSA_BITS_ADDR    = 4'h8; // rises clocking in the first byte
	localparam logic [3:0] I2CSA_BITS_SLOT    = 4'h9; // falls ending a byte plus ack slot
	localparam logic       I2CSA_RW_SLAVE_TX  = 1'h1;
	localparam int         I2CSA_RW_POS       = 0;
	localparam logic       I2CSA_RX_EN_INIT   = 1'h1;
	localparam logic       I2CSA_TX_EN_INIT   = 1'h0;
	localparam logic       I2CSA_STOP_EN_INIT = 1'h0;
	localparam logic [1:0] I2CSA_STATUS_INIT  = 2'h0;
	localparam int         I2CSA_ST_MISMATCH  = 0;
	localparam int         I2CSA_ST_DONE      = 1;
	localparam logic [7:0] I2CSA_COUNT_INIT   = 8'h00;
endpackage
`default_nettype wire

// ---- core/i2csa_line_if.sv ----
`default_nettype none
interface i2csa_line_if;
	logic scl_rise;  // synchronised scl rising edge
	logic scl_fall;  // synchronised scl falling edge
	logic sda_level; // filtered sda
	logic start_det; // sda falls while scl high
	logic stop_det;  // sda rises while scl high
	modport producer (output scl_rise, output scl_fall, output sda_level,
		output start_det, output stop_det);
	modport consumer (input scl_rise, input scl_fall, input sda_level,
		input start_det, input stop_det);
endinterface
`default_nettype wire

// ---- core/i2csa_line_sync.sv ----
`default_nettype none
module i2csa_line_sync
	import i2csa_pkg::*;
(
	input  wire logic      sys_clk,  // system clock
	input  wire logic      reset,    // async reset, active high
	input  wire logic      ce,       // clock enable
	input  wire logic      scl_in,   // raw scl pin level
	input  wire logic      sda_in,   // raw sda pin level
	i2csa_line_if.producer line      // conditioned bus events
);
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic       scl_f;
	logic       sda_f;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else if (ce) begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			scl_f <= 1'h1;
			sda_f <= 1'h1;
		end else if (ce) begin
			if (scl_sync[1] == scl_sync[2])
				scl_f <= scl_sync[2];
			if (sda_sync[1] == sda_sync[2])
				sda_f <= sda_sync[2];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			line.scl_rise  <= 1'h0;
			line.scl_fall  <= 1'h0;
			line.start_det <= 1'h0;
			line.stop_det  <= 1'h0;
			line.sda_level <= 1'h1;
		end else if (ce) begin
			line.scl_rise  <= (scl_sync[1] == scl_sync[2]) && scl_sync[2] && !scl_f;
			line.scl_fall  <= (scl_sync[1] == scl_sync[2]) && !scl_sync[2] && scl_f;
			line.start_det <= scl_f && (sda_sync[1] == sda_sync[2]) && !sda_sync[2] && sda_f;
			line.stop_det  <= scl_f && (sda_sync[1] == sda_sync[2]) && sda_sync[2] && !sda_f;
			line.sda_level <= sda_f;
		end
	end
endmodule // i2csa_line_sync
`default_nettype wire

// ---- verification/i2csa_master_model.sv ----
`default_nettype none
module i2csa_master_model (
	input  wire logic sys_clk,  // clock
	input  wire logic scl_wire, // resolved scl
	input  wire logic sda_wire, // resolved sda
	output logic      scl_drv,  // 0 pulls scl low
	output logic      sda_drv,  // 0 pulls sda low
	output logic      stuck     // scl never rose
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_drv = 1'h1;
		sda_drv = 1'h1;
		stuck = 1'h0;
	end
	task automatic gap(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// slave may stretch, so wait for the wire itself
	task automatic scl_up;
		int n;
		n = 0;
		scl_drv = 1'h1;
		while (scl_wire !== 1'h1 && n < 200) begin
			gap(1);
			n++;
		end
		if (n == 200) stuck = 1'h1;
	endtask
	task automatic clk_bit(input logic b, output logic s);
		gap(4);
		sda_drv = b;
		gap(8);
		scl_up;
		gap(12);
		s = sda_wire;
		scl_drv = 1'h0;
	endtask
	task automatic frame(input logic [7:0] b, output logic ack);
		logic s;
		sda_drv = 1'h0;
		gap(12);
		scl_drv = 1'h0;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'h1, s);
		ack = !s;
		// one data byte, sda released
		if (ack) for (int i = 0; i < 9; i++) clk_bit(1'h1, s);
		gap(4);
		sda_drv = 1'h0;
		gap(8);
		scl_up;
		gap(12);
		sda_drv = 1'h1;
		gap(12);
	endtask
endmodule // i2csa_master_model
`default_nettype wire

// ---- verification/i2csa_assertions.sv ----
`default_nettype none
module i2csa_assertions
	import i2csa_pkg::*;
(
	input wire logic       sys_clk,                  // clock
	input wire logic       reset,                    // reset
	input wire logic [6:0] own_addr,                 // address
	input wire logic [7:0] tx_data,                  // tx byte
	input wire logic       serial_clock_line_pin_oe, // stretch
	input wire logic       serial_data_pin_oe,       // ack
	input wire logic [7:0] rx_holding_register,      // first byte
	input wire logic       rx_event,                 // rx pulse
	input wire logic       tx_event,                 // tx pulse
	input wire logic       rx_event_en,              // rx enable
	input wire logic       tx_event_en,              // tx enable
	input wire logic       stop_event_en,            // stop enable
	input wire i2csa_buf_t buffer_sel,               // buffer
	input wire logic       ack_armed,                // armed
	input wire logic [7:0] tx_shift,                 // shift path
	input wire logic [7:0] byte_count,               // count
	input wire logic [1:0] status                    // status
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_rx_event_gate: assert property (rx_event |-> $past(rx_event_en) && !$past(rx_event))
		else $error("rx event not gated");
	a_stretch_start: assert property ($rose(serial_clock_line_pin_oe) |-> rx_event)
		else $error("stretch without rx event");
	a_hold_release: assert property (serial_clock_line_pin_oe |=> !serial_clock_line_pin_oe)
		else $error("scl hold not released");
	a_addr_compare: assert property (rx_event |=>
		(buffer_sel == I2CSA_BUF_NONE) == (rx_holding_register[7:1] != own_addr))
		else $error("address compare wrong");
	a_match_setup: assert property (rx_event ##1 buffer_sel != I2CSA_BUF_NONE |->
		serial_data_pin_oe && !rx_event_en && tx_event_en && stop_event_en
		&& byte_count == 8'h00 && status == 2'h0) else $error("match setup wrong");
	a_rx_arm: assert property (rx_event ##1 buffer_sel == I2CSA_BUF_RX |->
		ack_armed && !rx_holding_register[0]) else $error("receive not armed");
	a_tx_load: assert property (rx_event ##1 buffer_sel == I2CSA_BUF_TX |->
		tx_shift == $past(tx_data) && rx_holding_register[0]) else $error("tx byte not loaded");
	a_mismatch_nack: assert property (rx_event ##1 buffer_sel == I2CSA_BUF_NONE |->
		!serial_data_pin_oe && status[0]) else $error("mismatch not refused");
	a_ack_drop: assert property (tx_event |-> !serial_data_pin_oe && $past(tx_event_en))
		else $error("ack held past ninth fall");
	a_stop_restore: assert property ($fell(stop_event_en) |-> rx_event_en && !tx_event_en
		&& status[1] && buffer_sel == I2CSA_BUF_NONE) else $error("stop did not restore");
	c_rx_match: cover property (rx_event ##1 buffer_sel == I2CSA_BUF_RX);
	c_tx_match: cover property (rx_event ##1 buffer_sel == I2CSA_BUF_TX);
	c_mismatch: cover property (rx_event ##1 status[0]);
endmodule // i2csa_assertions
bind i2csa_top i2csa_assertions i2csa_assertions_i (.sys_clk(sys_clk), .reset(reset),
	.own_addr(own_addr), .tx_data(tx_data), .serial_data_pin_oe(serial_data_pin_oe),
	.serial_clock_line_pin_oe(serial_clock_line_pin_oe), .rx_event(rx_event),
	.rx_holding_register(rx_holding_register), .tx_event(tx_event), .rx_event_en(rx_event_en),
	.tx_event_en(tx_event_en), .stop_event_en(stop_event_en), .buffer_sel(buffer_sel),
	.ack_armed(ack_armed), .tx_shift(tx_shift), .byte_count(byte_count), .status(status));
`default_nettype wire

// ---- verification/i2csa_top_test.sv ----
`default_nettype none
module i2csa_top_test
	import i2csa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, reset, done_clr, scl_drv, sda_drv, stuck, ack;
	logic ce, tx_event, slave_tx;
	logic scl_out, scl_oe, sda_out, sda_oe, rx_event, rx_en, tx_en, stop_en, armed;
	logic [6:0] own_addr;
	logic [7:0] tx_data, rx_hold, tx_shift, byte_count, frame_byte;
	logic [1:0] status;
	i2csa_buf_t buffer_sel;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	int failures, check_count, tx_seen;
	wire scl_w = (scl_oe ? scl_out : 1'h1) & scl_drv;
	wire sda_w = (sda_oe ? sda_out : 1'h1) & sda_drv;
	i2csa_top i2csa_top_i (.sys_clk(sys_clk), .reset(reset), .ce(ce),
		.serial_clock_line_pin_in(scl_w), .serial_clock_line_pin_out(scl_out),
		.serial_clock_line_pin_oe(scl_oe), .serial_data_pin_in(sda_w),
		.serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe), .own_addr(own_addr),
		.tx_data(tx_data), .done_clr(done_clr), .rx_holding_register(rx_hold),
		.rx_event(rx_event), .tx_event(tx_event), .rx_event_en(rx_en), .tx_event_en(tx_en),
		.stop_event_en(stop_en), .buffer_sel(buffer_sel), .slave_tx(slave_tx),
		.ack_armed(armed),
		.tx_shift(tx_shift), .byte_count(byte_count), .status(status));
	i2csa_master_model i2csa_master_model_i (.sys_clk(sys_clk), .scl_wire(scl_w),
		.sda_wire(sda_w), .scl_drv(scl_drv), .sda_drv(sda_drv), .stuck(stuck));
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always #2 sys_clk = !sys_clk;
	// monitor: byte shows with the rx event, decision one cycle later
	always @(posedge sys_clk) begin
		#1;
		if (rx_event === 1'h1) begin
			e = exp_q.pop_front();
			check(rx_hold, e[7:0]);
			@(posedge sys_clk);
			#1;
			check(8'(buffer_sel), !e[8] ? 8'h00 : e[0] ? 8'h02 : 8'h01);
			check(8'(sda_oe), 8'(e[8]));
			if (e[8]) begin
				check({5'h0, rx_en, tx_en, stop_en}, 8'h03);
				check({byte_count[6:0], status[0]}, 8'h00);
				check(8'(armed), 8'(!e[0]));
				check(8'(slave_tx), 8'(e[0]));
				if (e[0]) check(tx_shift, tx_data);
			end else check(8'(status[0]), 8'h01);
		end
	end
	// counts transmit events of the current frame
	always @(posedge sys_clk) begin
		#1;
		if (tx_event === 1'h1) tx_seen++;
	end
	initial begin
		sys_clk = 1'h0;
		reset = 1'h1;
		done_clr = 1'h0;
		ce = 1'h1;
		tx_seen = 0;
		own_addr = 7'h00;
		tx_data = 8'h00;
		failures = 0;
		check_count = 0;
		void'($urandom(92504));
		repeat (6) @(posedge sys_clk);
		#1 reset = 1'h0;
		repeat (6) @(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			#1 own_addr = 7'($urandom);
			tx_data = 8'($urandom);
			tx_seen = 0;
			frame_byte = {own_addr ^ (i % 3 == 2 ? 7'h5A : 7'h00), 1'(i)};
			exp_q.push_back({i % 3 != 2, frame_byte});
			i2csa_master_model_i.frame(frame_byte, ack);
			if (stuck) begin
				failures++;
				close_out;
			end
			check(8'(ack), 8'(i % 3 != 2));
			check(8'(tx_seen), (i % 3 != 2) ? 8'h02 : 8'h00);
			if (i % 3 != 2) begin
				check({4'h0, rx_en, tx_en, stop_en, status[1]}, 8'h09);
				check(8'(buffer_sel), 8'h00);
				check(byte_count, 8'h01);
			end
			@(posedge sys_clk);
			#1 ce = 1'h0;
			done_clr = 1'h1;
			@(posedge sys_clk);
			// clear must not act while the block is frozen
			#1 check(8'(status[1]), 8'(i % 3 != 2));
			ce = 1'h1;
			@(posedge sys_clk);
			#1 done_clr = 1'h0;
			check(8'(status[1]), 8'h00);
		end
		check(8'(exp_q.size()), 8'h00);
		close_out;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		close_out;
	end
endmodule // i2csa_top_test
`default_nettype wire
